// ---- common/wts_cfg.svh ----
// offsets, field positions, command and response codes and timing counts of the wake-up sequencer
`ifndef WTS_CFG_SVH
`define WTS_CFG_SVH
`define WTS_CLK_HZ 100000000
`define WTS_SLOW_HI_HZ 32000
`define WTS_SLOW_LO_HZ 4000
`define WTS_WAKE_DELAY_US 6000
`define WTS_REF_TICKS 256
`define WTS_ADDR_WAKE_CFG 8'h00
`define WTS_ADDR_CTRL_CFG 8'h04
`define WTS_ADDR_TIMING 8'h08
`define WTS_ADDR_DETECT 8'h0C
`define WTS_ADDR_COMMAND 8'h10
`define WTS_ADDR_STATUS 8'h14
`define WTS_CMD_IDLE 8'h07
`define WTS_CMD_LEN 8'h0E
`define WTS_ENTER_HIBERNATE 16'h0400
`define WTS_SRC_TIMEOUT 0
`define WTS_SRC_TAG 1
`define WTS_SRC_WAKE_PIN 3
`define WTS_SRC_SEL_PIN 4
`define WTS_LIMIT_BITS 5
`define WTS_RESP_OKAY 2'b00
`define WTS_RESP_SLVERR 2'b10
`endif

// ---- common/wts_pkg.sv ----
// types shared by the wake-up sequencer
package wts_pkg;
    typedef enum logic [8:0] {
        ST_POWERUP = 9'b0_0000_0001,
        ST_WAKING = 9'b0_0000_0010,
        ST_READY = 9'b0_0000_0100,
        ST_HIBERNATE = 9'b0_0000_1000,
        ST_SLEEP = 9'b0_0001_0000,
        ST_OSC_SETTLE = 9'b0_0010_0000,
        ST_DAC_SETTLE = 9'b0_0100_0000,
        ST_BURST = 9'b0_1000_0000,
        ST_PAUSE = 9'b1_0000_0000
    } wts_state_t;
endpackage

// ---- sim/tb_top.sv ----
// self-checking bench for the wake-up sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, srst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, strap = 0;
    logic [7:0] aa = 0, ra = 0;
    logic [31:0] wd = 0, rdata;
    logic [5:0] dac = 0;
    logic [1:0] bresp, rresp;
    logic [3:0] ws = 4'hF;
    logic awr, wrd, bv, arr, rv, wk, ss, cs, so, sl, fo, de, rf, cmd_ready, iu;
    logic [65:0] eq[$];
    logic [65:0] e;
    logic [31:0] cfg[5] = '{32'h0021_000A, 32'h0021_0003, 32'h0001_0010, 32'h0004_0018,
        32'h0021_00C1};
    logic [7:0] why[5] = '{8'h02, 8'h01, 8'h10, 8'h00, 8'h01};
    int miscompares = 0, check_count = 0;
    wts_sequencer #(.WAKE_DELAY(50), .SLOW_DIV_HI(4), .SLOW_DIV_LO(8)) u_dut (.clock(clock),
        .srst(srst), .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .wake_in_n(wk), .serial_sel_n(ss),
        .iface_uart_pin(strap), .carrier_swing(cs), .dac_meas(dac), .slow_osc_en(so),
        .slow_osc_low(sl), .fast_osc_en(fo), .dac_en(de), .rf_burst_en(rf),
        .cmd_ready(cmd_ready), .iface_uart(iu));
    wts_host_model u_host (.clock(clock), .rf_burst_en(rf), .wake_in_n(wk),
        .serial_sel_n(ss), .carrier_swing(cs));
    initial forever #5 clock = ~clock;
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        eq.push_back({32'h0, a > 8'h10 ? 2'b10 : 2'b00, 32'h0});
        aa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        fork
            begin do @(posedge clock); while (!awr); awv <= 0; end
            begin do @(posedge clock); while (!wrd); wv <= 0; end
        join
        do @(posedge clock); while (!bv);
        bry <= 0;
    endtask
    // read notes its expected masked value, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [33:0] x, input logic [31:0] m);
        @(posedge clock);
        eq.push_back({m, x});
        ra <= a; arv <= 1; rry <= 1;
        do @(posedge clock); while (!arr);
        arv <= 0;
        do @(posedge clock); while (!rv);
        rry <= 0;
    endtask
    task automatic wait_ready;
        do @(posedge clock); while (!cmd_ready);
    endtask
    // monitor: oldest note against each read or write answer
    always @(posedge clock) if ((rv && rry) || (bv && bry))
    begin
        e = eq.pop_front();
        chk({rv ? rresp : bresp, rdata & e[65:34]}, e[33:0]);
    end
    initial
    begin
        repeat (30000) @(posedge clock);
        miscompares++;
        give_verdict;
    end
    // main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        srst <= 0;
        void'($urandom(40));
        strap <= 1'($urandom % 2);
        u_host.pulse(0);
        wait_ready;
        rd(8'h14, {2'b00, 16'h0004, strap, 15'h0}, 32'h01FF_8000);
        rd(8'h18, {2'b10, 32'h0}, 32'hFFFF_FFFF);
        wr(8'h10, 32'h0000_0F07);
        rd(8'h14, {2'b00, 32'h0004_4000}, 32'h01FF_4000);
        wr(8'h14, 32'h0000_00FF);
        ws <= 4'h3;
        wr(8'h04, 32'hA5A5_5A5A);
        ws <= 4'hF;
        rd(8'h04, {2'b00, 32'h0000_5A5A}, 32'hFFFF_FFFF);
        wr(8'h08, 32'h0001_0100);
        // calibration sweep: low fixed at zero, high stepped down
        dac <= 6'h20;
        for (int h = 'hFE; h >= 0; h -= 'h70)
        begin
            wr(8'h0C, 32'h0103_0000 | (h << 8));
            wr(8'h00, 32'h0021_0003);
            wr(8'h10, 32'h0000_0E07);
            wait_ready;
            rd(8'h14, {2'b00, 16'h0004, 8'h00, h > 'h20 ? 8'h01 : 8'h02},
               32'h01FF_40FF);
        end
        wr(8'h0C, 32'h0103_2010);
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h00, cfg[i]);
            dac <= (i == 0) ? 6'h30 : 6'(8'h11 + $urandom % 14);
            wr(8'h10, 32'h0000_0E07);
            repeat (20) @(posedge clock);
            if (i == 4) chk({32'h0, so, sl}, 34'h3);
            if (i == 2 || i == 3) u_host.pulse(1);
            if (i == 3) repeat (20) @(posedge clock);
            if (i == 3) rd(8'h14, 34'h0008_0000, 32'h01FF_0000);
            if (i == 3) u_host.pulse(0);
            wait_ready;
            rd(8'h14, {2'b00, 16'h0004, 8'h00, why[i]},
               i == 3 ? 32'h01FF_4000 : 32'h01FF_40FF);
        end
        give_verdict;
    end
endmodule

// ---- sim/wts_host_model.sv ----
// host-side model: wake and select pins plus the carrier seen during bursts
module wts_host_model (
    // clock and burst status
    input wire logic clock,
    input wire logic rf_burst_en,
    // pins toward the device
    output logic wake_in_n,
    output logic serial_sel_n,
    output logic carrier_swing
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins idle high, no carrier before the first burst
    initial
    begin
        wake_in_n = 1'b1;
        serial_sel_n = 1'b1;
        carrier_swing = 1'b0;
    end
    // carrier toggles only while the burst is driven
    always @(posedge clock) carrier_swing <= rf_burst_en ? ~carrier_swing : 1'b0;
    // low pulse of four cycles on the wake pin or the select pin
    task automatic pulse(input bit sel);
        @(posedge clock);
        if (sel) serial_sel_n <= 1'b0; else wake_in_n <= 1'b0;
        repeat (4) @(posedge clock);
        serial_sel_n <= 1'b1;
        wake_in_n <= 1'b1;
    endtask
endmodule

// ---- verilog/wts_sequencer.sv ----
// wake-up and tag-detect sequencer with AXI4-Lite register access
`include "wts_cfg.svh"
module wts_sequencer #(
    parameter int WAKE_DELAY = `WTS_WAKE_DELAY_US * (`WTS_CLK_HZ / 1000000),
    parameter int SLOW_DIV_HI = `WTS_CLK_HZ / `WTS_SLOW_HI_HZ,
    parameter int SLOW_DIV_LO = `WTS_CLK_HZ / `WTS_SLOW_LO_HZ
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins from the host
    input wire logic wake_in_n,
    input wire logic serial_sel_n,
    input wire logic iface_uart_pin,
    // analog front end
    input wire logic carrier_swing,
    input wire logic [5:0] dac_meas,
    // resource controls and state
    output logic slow_osc_en,
    output logic slow_osc_low,
    output logic fast_osc_en,
    output logic dac_en,
    output logic rf_burst_en,
    output logic cmd_ready,
    output logic iface_uart
);
    wts_pkg::wts_state_t state_r, state_nxt;
    logic [3:0] pins_s;
    logic wake_d_r, sel_d_r, swing_d_r;
    logic wake_fall, sel_fall, swing_rise, tick, pin_evt, go_idle;
    logic [31:0] wake_cfg_r, ctrl_cfg_r, timing_r, detect_r;
    logic [7:0] aw_addr_r, reason_r, reason_nxt;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_have_r, w_have_r, cmd_reject_r;
    logic [23:0] cnt_r;
    logic [4:0] burst_cnt_r;
    logic [7:0] swing_cnt_r;
    logic [5:0] dac_data_r;
    logic outside, limit_hit, do_write, settle_done;
    logic [7:0] src, interval, osc_cnt, dac_cnt, thr_lo, thr_hi, swing_lim;
    logic [4:0] limit;

    // field views of the parameter registers
    assign src = wake_cfg_r[7:0];
    assign interval = timing_r[7:0];
    assign osc_cnt = timing_r[15:8];
    assign dac_cnt = timing_r[23:16];
    assign thr_lo = detect_r[7:0];
    assign thr_hi = detect_r[15:8];
    assign swing_lim = detect_r[23:16];
    assign limit = detect_r[24 +: `WTS_LIMIT_BITS];

    // slow periods in n reference periods of (interval + 2) * 256
    function automatic logic [23:0] ref_ticks(input logic [7:0] coeff, input logic [5:0] mult);
        ref_ticks = 24'(({16'h0000, coeff} + 24'h00_0002) * `WTS_REF_TICKS * mult);
    endfunction

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                merge[8*i +: 8] = din[8*i +: 8];
    endfunction

    // host pins through two flops
    wts_sync #(.WIDTH(4)) u_sync (
        .clock(clock),
        .srst(srst),
        .pin_in({iface_uart_pin, carrier_swing, serial_sel_n, wake_in_n}),
        .sync_out(pins_s)
    );

    // slow clock, frequency picked by wake-source bits 7:6
    wts_slow_tick #(.DIV_HI(SLOW_DIV_HI), .DIV_LO(SLOW_DIV_LO)) u_tick (
        .clock(clock),
        .srst(srst),
        .run(slow_osc_en),
        .low_freq(slow_osc_low),
        .tick(tick)
    );

    // edge detection on synchronised pins
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wake_d_r <= 1'b1;
            sel_d_r <= 1'b1;
            swing_d_r <= 1'b1; // synchroniser resets high, so no false rise
        end
        else
        begin
            wake_d_r <= pins_s[0];
            sel_d_r <= pins_s[1];
            swing_d_r <= pins_s[2];
        end
    end
    assign wake_fall = wake_d_r & ~pins_s[0];
    assign sel_fall = sel_d_r & ~pins_s[1];
    assign swing_rise = ~swing_d_r & pins_s[2];
    // any enabled pin source stops the wait
    assign pin_evt = (src[`WTS_SRC_WAKE_PIN] & wake_fall) | (src[`WTS_SRC_SEL_PIN] & sel_fall);

    // axi write path: address and data in either order
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    assign go_idle = do_write && aw_addr_r == `WTS_ADDR_COMMAND && state_r == wts_pkg::ST_READY
                     && w_data_r[7:0] == `WTS_CMD_IDLE && w_data_r[15:8] == `WTS_CMD_LEN;
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WTS_RESP_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r > `WTS_ADDR_COMMAND) ? `WTS_RESP_SLVERR : `WTS_RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    // parameter registers and command rejection flag
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wake_cfg_r <= 32'h0000_0000;
            ctrl_cfg_r <= 32'h0000_0000;
            timing_r <= 32'h0000_0000;
            detect_r <= 32'h0000_0000;
            cmd_reject_r <= 1'b0;
        end
        else if (do_write)
        begin
            case (aw_addr_r)
                `WTS_ADDR_WAKE_CFG: wake_cfg_r <= merge(wake_cfg_r, w_data_r, w_strb_r) & 32'h00FF_FFFF;
                `WTS_ADDR_CTRL_CFG: ctrl_cfg_r <= merge(ctrl_cfg_r, w_data_r, w_strb_r);
                `WTS_ADDR_TIMING: timing_r <= merge(timing_r, w_data_r, w_strb_r) & 32'h00FF_FFFF;
                `WTS_ADDR_DETECT: detect_r <= merge(detect_r, w_data_r, w_strb_r) & 32'h1FFF_FFFF;
                `WTS_ADDR_COMMAND: cmd_reject_r <= !go_idle;
                default: cmd_reject_r <= cmd_reject_r;
            endcase
        end
    end

    // axi read path with one-cycle answer
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `WTS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `WTS_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `WTS_ADDR_WAKE_CFG: s_axi_rdata <= wake_cfg_r;
                `WTS_ADDR_CTRL_CFG: s_axi_rdata <= ctrl_cfg_r;
                `WTS_ADDR_TIMING: s_axi_rdata <= timing_r;
                `WTS_ADDR_DETECT: s_axi_rdata <= detect_r;
                `WTS_ADDR_COMMAND: s_axi_rdata <= 32'h0000_0000;
                `WTS_ADDR_STATUS: s_axi_rdata <= {7'h00, state_r, iface_uart, cmd_reject_r,
                                                  dac_data_r, reason_r};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `WTS_RESP_SLVERR;
                end
            endcase
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid || s_axi_rready;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // measurement comparison and burst budget
    assign outside = ({2'b00, dac_meas} > thr_hi) || ({2'b00, dac_meas} < thr_lo);
    assign limit_hit = src[`WTS_SRC_TIMEOUT] && burst_cnt_r == limit;
    assign settle_done = (state_r == wts_pkg::ST_OSC_SETTLE) ? cnt_r >= {16'h0000, osc_cnt}
                                                            : cnt_r >= {16'h0000, dac_cnt};

    // next state and wake reason
    always_comb
    begin
        state_nxt = state_r;
        reason_nxt = reason_r;
        case (state_r)
            wts_pkg::ST_POWERUP:
                if (wake_fall)
                    state_nxt = wts_pkg::ST_WAKING;
            wts_pkg::ST_WAKING:
                if (cnt_r >= 24'(WAKE_DELAY - 1))
                    state_nxt = wts_pkg::ST_READY;
            wts_pkg::ST_READY:
                if (go_idle)
                begin
                    if (wake_cfg_r[23:8] == `WTS_ENTER_HIBERNATE)
                        state_nxt = wts_pkg::ST_HIBERNATE;
                    else if (src[`WTS_SRC_TAG])
                        state_nxt = wts_pkg::ST_OSC_SETTLE;
                    else
                        state_nxt = wts_pkg::ST_SLEEP;
                end
            wts_pkg::ST_HIBERNATE:
                if (wake_fall)
                    state_nxt = wts_pkg::ST_READY;
            wts_pkg::ST_SLEEP:
                if (pin_evt)
                begin
                    state_nxt = wts_pkg::ST_READY;
                    reason_nxt = {3'b000, src[4] & sel_fall, src[3] & wake_fall, 3'b000};
                end
                else if (src[`WTS_SRC_TIMEOUT] && tick
                         && cnt_r + 24'h00_0001 >= ref_ticks(interval, {1'b0, limit} + 6'h01))
                begin
                    state_nxt = wts_pkg::ST_READY;
                    reason_nxt = 8'h01;
                end
            wts_pkg::ST_OSC_SETTLE, wts_pkg::ST_DAC_SETTLE, wts_pkg::ST_BURST,
            wts_pkg::ST_PAUSE:
                if (pin_evt)
                begin
                    state_nxt = wts_pkg::ST_READY;
                    reason_nxt = {3'b000, src[4] & sel_fall, src[3] & wake_fall, 3'b000};
                end
                else if (state_r == wts_pkg::ST_BURST)
                begin
                    if (swing_cnt_r >= swing_lim)
                    begin
                        if (outside)
                        begin
                            state_nxt = wts_pkg::ST_READY;
                            reason_nxt = 8'h02;
                        end
                        else if (limit_hit)
                        begin
                            state_nxt = wts_pkg::ST_READY;
                            reason_nxt = 8'h01;
                        end
                        else
                            state_nxt = wts_pkg::ST_PAUSE;
                    end
                end
                else if (state_r == wts_pkg::ST_PAUSE)
                begin
                    if (tick && cnt_r + 24'h00_0001 >= ref_ticks(interval, 6'h01))
                        state_nxt = wts_pkg::ST_OSC_SETTLE;
                end
                else if (settle_done)
                    state_nxt = (state_r == wts_pkg::ST_OSC_SETTLE) ? wts_pkg::ST_DAC_SETTLE
                                                                    : wts_pkg::ST_BURST;
            default:
                state_nxt = wts_pkg::ST_POWERUP;
        endcase
    end

    // state and wake reason registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_r <= wts_pkg::ST_POWERUP;
            reason_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            reason_r <= reason_nxt;
        end
    end

    // shared counter: cycles while waking, slow ticks elsewhere
    always_ff @(posedge clock)
    begin
        if (srst || state_nxt != state_r)
            cnt_r <= 24'h00_0000;
        else if (state_r == wts_pkg::ST_WAKING || tick)
            cnt_r <= cnt_r + 24'h00_0001;
    end

    // bursts done in this detection run
    always_ff @(posedge clock)
    begin
        if (srst || state_r == wts_pkg::ST_READY)
            burst_cnt_r <= 5'h00;
        else if (state_r == wts_pkg::ST_BURST && state_nxt == wts_pkg::ST_PAUSE)
            burst_cnt_r <= burst_cnt_r + 5'h01;
    end

    // carrier swings in the current burst and the measurement it leaves
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            swing_cnt_r <= 8'h00;
            dac_data_r <= 6'h00;
        end
        else if (state_r != wts_pkg::ST_BURST)
            swing_cnt_r <= 8'h00;
        else
        begin
            if (swing_rise && swing_cnt_r < swing_lim)
                swing_cnt_r <= swing_cnt_r + 8'h01;
            if (swing_cnt_r >= swing_lim)
                dac_data_r <= dac_meas;
        end
    end

    // resource enables follow the next state
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            slow_osc_en <= 1'b0;
            slow_osc_low <= 1'b0;
            fast_osc_en <= 1'b0;
            dac_en <= 1'b0;
            rf_burst_en <= 1'b0;
            cmd_ready <= 1'b0;
            iface_uart <= 1'b0;
        end
        else
        begin
            slow_osc_en <= (state_nxt == wts_pkg::ST_SLEEP && src[`WTS_SRC_TIMEOUT])
                           || (state_nxt inside {wts_pkg::ST_OSC_SETTLE, wts_pkg::ST_DAC_SETTLE,
                                                 wts_pkg::ST_BURST, wts_pkg::ST_PAUSE});
            slow_osc_low <= src[7:6] == 2'b11;
            fast_osc_en <= state_nxt inside {wts_pkg::ST_OSC_SETTLE, wts_pkg::ST_DAC_SETTLE,
                                             wts_pkg::ST_BURST};
            dac_en <= state_nxt inside {wts_pkg::ST_DAC_SETTLE, wts_pkg::ST_BURST};
            rf_burst_en <= state_nxt == wts_pkg::ST_BURST && src[`WTS_SRC_TAG];
            cmd_ready <= state_nxt == wts_pkg::ST_READY;
            if (state_r == wts_pkg::ST_POWERUP && wake_fall)
                iface_uart <= pins_s[3];
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_hib_quiet;
        state_r == wts_pkg::ST_HIBERNATE && !wake_fall;
    endsequence
    property p_hib_pin_only;
        s_hib_quiet |=> state_r == wts_pkg::ST_HIBERNATE;
    endproperty
    a_hib_pin_only: assert property (p_hib_pin_only) else $error("hibernate left without pin");

    property p_powerup_wake;
        state_r == wts_pkg::ST_POWERUP && wake_fall |=> state_r == wts_pkg::ST_WAKING ##1 !cmd_ready;
    endproperty
    a_powerup_wake: assert property (p_powerup_wake) else $error("power-up wake mishandled");

    property p_burst_tag;
        rf_burst_en |-> src[`WTS_SRC_TAG] && state_r == wts_pkg::ST_BURST;
    endproperty
    a_burst_tag: assert property (p_burst_tag) else $error("burst without tag enable");

    property p_tag_reason;
        state_r == wts_pkg::ST_BURST && swing_cnt_r >= swing_lim && outside && !pin_evt
        |=> state_r == wts_pkg::ST_READY && reason_r == 8'h02;
    endproperty
    a_tag_reason: assert property (p_tag_reason) else $error("tag event not reported");

    property p_timer_osc;
        state_r == wts_pkg::ST_SLEEP && src[`WTS_SRC_TIMEOUT] |-> slow_osc_en;
    endproperty
    a_timer_osc: assert property (p_timer_osc) else $error("slow oscillator off in timer sleep");

    property p_burst_bound;
        src[`WTS_SRC_TIMEOUT] && state_r != wts_pkg::ST_READY |-> burst_cnt_r <= limit;
    endproperty
    a_burst_bound: assert property (p_burst_bound) else $error("too many bursts");

    property p_cmd_reject;
        do_write && aw_addr_r == `WTS_ADDR_COMMAND && !go_idle |=> cmd_reject_r && $stable(state_r);
    endproperty
    a_cmd_reject: assert property (p_cmd_reject) else $error("bad command accepted");

    property p_slow_freq;
        state_r == wts_pkg::ST_SLEEP |-> slow_osc_low == (src[7:6] == 2'b11);
    endproperty
    a_slow_freq: assert property (p_slow_freq) else $error("slow clock select wrong");

    property p_dac_store;
        state_r == wts_pkg::ST_BURST && swing_cnt_r >= swing_lim |=> dac_data_r == $past(dac_meas);
    endproperty
    a_dac_store: assert property (p_dac_store) else $error("dac value not stored");
endmodule

// ---- verilog/wts_slow_tick.sv ----
// slow oscillator model: one-cycle tick per slow period while enabled
module wts_slow_tick #(
    parameter int DIV_HI = 3125,
    parameter int DIV_LO = 25000
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control
    input wire logic run,
    input wire logic low_freq,
    // tick out
    output logic tick
);
    logic [14:0] div_r;
    logic [14:0] last;

    assign last = low_freq ? 15'(DIV_LO - 1) : 15'(DIV_HI - 1);

    // divider stops and clears while the oscillator is off
    always_ff @(posedge clock)
    begin
        if (srst || !run)
        begin
            div_r <= 15'h0000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (div_r >= last);
            div_r <= (div_r >= last) ? 15'h0000 : div_r + 15'h0001;
        end
    end
endmodule

// ---- verilog/wts_sync.sv ----
// two-flop synchroniser for a group of pin inputs
module wts_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // wake and select pins idle high, so reset to ones
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            meta_r <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_r <= pin_in;
            sync_out <= meta_r;
        end
    end
endmodule
